// >>> vectoring_pkg.sv
`default_nettype none
package vectoring_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_PRIO_A = 8'h00;
  localparam logic [7:0] OFF_VECTOR_BASE = 8'h04;
  localparam logic [7:0] OFF_CONTROL = 8'h08;
  localparam logic [7:0] OFF_EXT_LEVELS = 8'h0c;
  localparam logic [7:0] OFF_VEC_DMA = 8'h10;
  localparam logic [7:0] OFF_VEC_WATCHDOG = 8'h14;
  localparam logic [7:0] OFF_VECTOR_NUMBER_B = 8'h18;
  localparam logic [7:0] OFF_ETH_STATUS = 8'h1c;
  localparam logic [7:0] OFF_ETH_ENABLE = 8'h20;
  localparam logic [7:0] OFF_LINK_STATUS = 8'h24;
  localparam logic [7:0] OFF_LINK_ENABLE = 8'h28;
  localparam logic [7:0] OFF_WINNER = 8'h2c;
  localparam logic [15:0] PRIO_A_RESET = 16'h0000;
  localparam logic [15:0] PRIO_A_WRITABLE = 16'h0ff0;
  localparam int unsigned DMA_LVL_LSB = 8;
  localparam int unsigned WDT_LVL_LSB = 4;
  localparam int unsigned LVL_W = 4;
  localparam int unsigned VEC_W = 7;
  localparam int unsigned VEC_HI_LSB = 8;
  localparam int unsigned VEC_LO_LSB = 0;
  localparam logic [15:0] VEC_PAIR_MASK = 16'h7f7f;
  localparam int unsigned CTL_MODE_BIT = 0;
  localparam int unsigned CTL_EXTVEC_BIT = 1;
  localparam logic [6:0] AUTO_VECTOR_BASE = 7'h40;
  localparam int unsigned ETH_CAUSES = 19;
  localparam int unsigned LINK_CAUSES = 3;
  localparam int unsigned NSRC = 5;
  localparam int unsigned SRC_DMA0 = 0;
  localparam int unsigned SRC_DMA1 = 1;
  localparam int unsigned SRC_WDT = 2;
  localparam int unsigned SRC_REF = 3;
  localparam int unsigned SRC_EXT = 4;
  typedef enum logic [1:0] {
    APB_IDLE = 2'b00,
    APB_WAIT = 2'b01,
    APB_DONE = 2'b10
  } apb_state_e;
endpackage
`default_nettype wire

// >>> level_arbiter.sv
`default_nettype none
module level_arbiter
  import vectoring_pkg::*;
#(
  parameter int unsigned N = NSRC
) (
  input wire logic [N-1:0] req,
  input wire logic [N*LVL_W-1:0] levels,
  output logic found,
  output logic [LVL_W-1:0] best_level,
  output logic [$clog2(N)-1:0] best_index
);
  if (N < 2) begin : g_chk
    $error("level_arbiter needs two sources or more");
  end

  // Level zero never wins; it masks the source
  always_comb begin
    found = 1'b0;
    best_level = '0;
    best_index = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i] && levels[i*LVL_W +: LVL_W] != '0 && levels[i*LVL_W +: LVL_W] >= best_level) begin // see RULE15
        found = 1'b1;
        best_level = levels[i*LVL_W +: LVL_W];
        best_index = i[$clog2(N)-1:0];
      end
    end
  end
endmodule // level_arbiter
`default_nettype wire

// >>> eth_event_merge.sv
`default_nettype none
module eth_event_merge
  import vectoring_pkg::*;
#(
  parameter int unsigned NCAUSE = ETH_CAUSES,
  parameter int unsigned NLINK = LINK_CAUSES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic manual_rst,
  input wire logic [NCAUSE-1:0] cause_set,
  input wire logic [NLINK-1:0] link_set,
  input wire logic wr_status,
  input wire logic wr_enable,
  input wire logic wr_link,
  input wire logic wr_link_enable,
  input wire logic [31:0] wdata,
  output logic [NCAUSE:0] status,
  output logic [NCAUSE:0] enable_r,
  output logic [NLINK-1:0] link_r,
  output logic [NLINK-1:0] link_enable_r,
  output logic event_r
);
  if (NCAUSE + NLINK + 1 > 32) begin : g_chk
    $error("eth_event_merge causes exceed one word");
  end
  logic [NCAUSE-1:0] cause_r;
  logic summary;

  assign summary = |(link_r & link_enable_r); // see RULE13
  assign status = {summary, cause_r};

  // Set beats a same-cycle write-one clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cause_r <= '0;
    end else if (manual_rst) begin
      cause_r <= '0;
    end else begin
      cause_r <= (cause_r & ~(wr_status ? wdata[NCAUSE-1:0] : '0)) | cause_set;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      link_r <= '0;
    end else if (manual_rst) begin
      link_r <= '0;
    end else begin
      link_r <= (link_r & ~(wr_link ? wdata[NLINK-1:0] : '0)) | link_set;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      enable_r <= '0;
      link_enable_r <= '0;
    end else if (manual_rst) begin
      enable_r <= '0;
      link_enable_r <= '0;
    end else begin
      if (wr_enable) begin
        enable_r <= wdata[NCAUSE:0];
      end
      if (wr_link_enable) begin
        link_enable_r <= wdata[NLINK-1:0];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      event_r <= 1'b0;
    end else if (manual_rst) begin
      event_r <= 1'b0;
    end else begin
      event_r <= |(status & enable_r); // see RULE12
    end
  end
endmodule // eth_event_merge
`default_nettype wire

// >>> peripheral_interrupt_priority_vectoring.sv
// The APB register port and the placing of the registers were decided locally.
`default_nettype none
// Notes on behaviour
// RULE1: Priority register A: 16 bits, resets zero
// RULE2: Standby never alters priority register contents
// RULE3: Power-on and manual reset both initialise
// RULE4: Reserved bits read zero, software writes zero
// RULE5: Bits 11:8 hold DMA level 0-15
// RULE6: DMA channels share level; channel 0 first
// RULE7: Bits 7:4 shared watchdog and refresh level
// RULE8: Watchdog beats refresh at equal level
// RULE9: On-chip vector numbers 0-127 from registers
// RULE10: External vector fetch alternative, values 0-127
// RULE11: Mode bit picks encoded or individual pins
// RULE12: Ethernet event ORs enabled status causes
// RULE13: Link status bits fold into summary cause
// RULE14: Software never touches vector number B
// RULE15: Equal levels: first-listed source wins
// RULE16: Vector address is base plus four times number
// RULE17: Numbers 128-255 never generated on-chip
module peripheral_interrupt_priority_vectoring
  import vectoring_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic manual_rst,
  input wire logic standby,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dma0_req,
  input wire logic dma1_req,
  input wire logic watchdog_interval_event,
  input wire logic refresh_compare_match,
  input wire logic [3:0] encoded_level_inputs,
  input wire logic [3:0] irq_pins,
  input wire logic [6:0] ext_vector_in,
  input wire logic [ETH_CAUSES-1:0] eth_cause_set,
  input wire logic [LINK_CAUSES-1:0] link_cause_set,
  output logic irq_request,
  output logic [LVL_W-1:0] irq_level,
  output logic [VEC_W-1:0] irq_vector,
  output logic [31:0] irq_vector_addr,
  output logic ethernet_dma_event
);
  localparam int unsigned IDX_W = $clog2(NSRC);

  logic [15:0] peripheral_priority_a_r;
  logic [31:0] vector_base_r;
  logic [1:0] interrupt_control_reg_r;
  logic [15:0] ext_levels_r;
  logic [15:0] vec_dma_r;
  logic [15:0] vec_watchdog_r;
  apb_state_e apb_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic irq_request_r;
  logic [LVL_W-1:0] irq_level_r;
  logic [VEC_W-1:0] irq_vector_r;
  logic [31:0] irq_vector_addr_r;
  logic wr_commit;
  logic [31:0] rd_nxt;
  logic bad_nxt;
  logic [ETH_CAUSES:0] eth_status;
  logic [ETH_CAUSES:0] eth_enable;
  logic [LINK_CAUSES-1:0] link_status;
  logic [LINK_CAUSES-1:0] link_enable;
  logic eth_event;
  logic [NSRC-1:0] src_req;
  logic [NSRC*LVL_W-1:0] src_lvl;
  logic win_found;
  logic [LVL_W-1:0] win_level;
  logic [IDX_W-1:0] win_index;
  logic ext_req;
  logic [LVL_W-1:0] ext_level;
  logic [VEC_W-1:0] ext_auto_vec;
  logic [VEC_W-1:0] vec_nxt;

  function automatic logic sel(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    sel = (a == off[ADDR_W-1:0]);
  endfunction

  function automatic logic [VEC_W-1:0] vec_field(input logic [15:0] r, input int unsigned lsb);
    vec_field = r[lsb +: VEC_W];
  endfunction

  // Writes land only at the edge where the master sees pready
  assign wr_commit = (apb_r == APB_DONE) && psel && penable && pwrite && !pslverr_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      apb_r <= APB_IDLE;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else if (manual_rst) begin // see RULE3
      apb_r <= APB_IDLE;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      unique case (apb_r)
        APB_IDLE: begin
          if (psel && penable) begin
            apb_r <= APB_DONE;
            pready_r <= 1'b1;
            pslverr_r <= bad_nxt;
            prdata_r <= pwrite ? '0 : rd_nxt;
          end
        end
        APB_WAIT: begin
          apb_r <= APB_IDLE;
        end
        APB_DONE: begin
          apb_r <= APB_IDLE;
          pready_r <= 1'b0;
          pslverr_r <= 1'b0;
        end
        default: begin
          apb_r <= APB_IDLE;
        end
      endcase
    end
  end

  // Reserved word and unmapped addresses answer with an error
  always_comb begin
    rd_nxt = '0;
    bad_nxt = 1'b0;
    if (sel(paddr, OFF_PRIO_A)) begin
      rd_nxt = {16'h0000, peripheral_priority_a_r & PRIO_A_WRITABLE}; // see RULE4
    end else if (sel(paddr, OFF_VECTOR_BASE)) begin
      rd_nxt = vector_base_r;
    end else if (sel(paddr, OFF_CONTROL)) begin
      rd_nxt = {30'h0, interrupt_control_reg_r};
    end else if (sel(paddr, OFF_EXT_LEVELS)) begin
      rd_nxt = {16'h0000, ext_levels_r};
    end else if (sel(paddr, OFF_VEC_DMA)) begin
      rd_nxt = {16'h0000, vec_dma_r};
    end else if (sel(paddr, OFF_VEC_WATCHDOG)) begin
      rd_nxt = {16'h0000, vec_watchdog_r};
    end else if (sel(paddr, OFF_VECTOR_NUMBER_B)) begin
      bad_nxt = 1'b1; // see RULE14
    end else if (sel(paddr, OFF_ETH_STATUS)) begin
      rd_nxt = {{(31-ETH_CAUSES){1'b0}}, eth_status};
    end else if (sel(paddr, OFF_ETH_ENABLE)) begin
      rd_nxt = {{(31-ETH_CAUSES){1'b0}}, eth_enable};
    end else if (sel(paddr, OFF_LINK_STATUS)) begin
      rd_nxt = {{(32-LINK_CAUSES){1'b0}}, link_status};
    end else if (sel(paddr, OFF_LINK_ENABLE)) begin
      rd_nxt = {{(32-LINK_CAUSES){1'b0}}, link_enable};
    end else if (sel(paddr, OFF_WINNER)) begin
      rd_nxt = {16'h0000, irq_request_r, irq_level_r, 4'h0, irq_vector_r};
    end else begin
      bad_nxt = 1'b1;
    end
  end

  // Standby is not an input here on purpose: nothing but reset clears state
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      peripheral_priority_a_r <= PRIO_A_RESET; // see RULE1
    end else if (manual_rst) begin
      peripheral_priority_a_r <= PRIO_A_RESET; // see RULE3
    end else if (wr_commit && sel(paddr, OFF_PRIO_A)) begin
      peripheral_priority_a_r <= pwdata[15:0] & PRIO_A_WRITABLE; // see RULE2
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      vector_base_r <= '0;
      interrupt_control_reg_r <= '0;
      ext_levels_r <= '0;
    end else if (manual_rst) begin
      vector_base_r <= '0;
      interrupt_control_reg_r <= '0;
      ext_levels_r <= '0;
    end else if (wr_commit) begin
      if (sel(paddr, OFF_VECTOR_BASE)) begin
        vector_base_r <= pwdata;
      end
      if (sel(paddr, OFF_CONTROL)) begin
        interrupt_control_reg_r <= pwdata[1:0];
      end
      if (sel(paddr, OFF_EXT_LEVELS)) begin
        ext_levels_r <= pwdata[15:0];
      end
    end
  end

  // Bit 7 of each byte is kept clear so no number above 127 exists
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      vec_dma_r <= '0;
      vec_watchdog_r <= '0;
    end else if (manual_rst) begin
      vec_dma_r <= '0;
      vec_watchdog_r <= '0;
    end else if (wr_commit) begin
      if (sel(paddr, OFF_VEC_DMA)) begin
        vec_dma_r <= pwdata[15:0] & VEC_PAIR_MASK; // see RULE9
      end
      if (sel(paddr, OFF_VEC_WATCHDOG)) begin
        vec_watchdog_r <= pwdata[15:0] & VEC_PAIR_MASK; // see RULE9
      end
    end
  end

  eth_event_merge #(
    .NCAUSE(ETH_CAUSES),
    .NLINK(LINK_CAUSES)
  ) u_eth (
    .mclk(mclk),
    .rst(rst),
    .manual_rst(manual_rst),
    .cause_set(eth_cause_set),
    .link_set(link_cause_set),
    .wr_status(wr_commit && sel(paddr, OFF_ETH_STATUS)),
    .wr_enable(wr_commit && sel(paddr, OFF_ETH_ENABLE)),
    .wr_link(wr_commit && sel(paddr, OFF_LINK_STATUS)),
    .wr_link_enable(wr_commit && sel(paddr, OFF_LINK_ENABLE)),
    .wdata(pwdata),
    .status(eth_status),
    .enable_r(eth_enable),
    .link_r(link_status),
    .link_enable_r(link_enable),
    .event_r(eth_event)
  );

  // External request: encoded level, or highest-ranked individual pin
  always_comb begin
    ext_req = 1'b0;
    ext_level = '0;
    ext_auto_vec = AUTO_VECTOR_BASE;
    if (!interrupt_control_reg_r[CTL_MODE_BIT]) begin // see RULE11
      ext_req = (encoded_level_inputs != 4'h0);
      ext_level = encoded_level_inputs;
      ext_auto_vec = AUTO_VECTOR_BASE + {3'h0, encoded_level_inputs};
    end else begin
      for (int i = 3; i >= 0; i--) begin
        if (irq_pins[i]) begin
          ext_req = 1'b1;
          ext_level = ext_levels_r[(3-i)*LVL_W +: LVL_W];
          ext_auto_vec = AUTO_VECTOR_BASE + 7'(i);
        end
      end
    end
  end

  // Shared fields: same level, table order breaks the tie
  always_comb begin
    src_req = {ext_req, refresh_compare_match, watchdog_interval_event, dma1_req, dma0_req};
    src_lvl = '0;
    src_lvl[SRC_DMA0*LVL_W +: LVL_W] = peripheral_priority_a_r[DMA_LVL_LSB +: LVL_W]; // see RULE5
    src_lvl[SRC_DMA1*LVL_W +: LVL_W] = peripheral_priority_a_r[DMA_LVL_LSB +: LVL_W]; // see RULE6
    src_lvl[SRC_WDT*LVL_W +: LVL_W] = peripheral_priority_a_r[WDT_LVL_LSB +: LVL_W]; // see RULE7
    src_lvl[SRC_REF*LVL_W +: LVL_W] = peripheral_priority_a_r[WDT_LVL_LSB +: LVL_W]; // see RULE8
    src_lvl[SRC_EXT*LVL_W +: LVL_W] = ext_level;
  end

  level_arbiter #(
    .N(NSRC)
  ) u_arb (
    .req(src_req),
    .levels(src_lvl),
    .found(win_found),
    .best_level(win_level),
    .best_index(win_index)
  );

  always_comb begin
    vec_nxt = '0;
    unique case (win_index)
      IDX_W'(SRC_DMA0): vec_nxt = vec_field(vec_dma_r, VEC_LO_LSB);
      IDX_W'(SRC_DMA1): vec_nxt = vec_field(vec_dma_r, VEC_HI_LSB);
      IDX_W'(SRC_WDT): vec_nxt = vec_field(vec_watchdog_r, VEC_HI_LSB);
      IDX_W'(SRC_REF): vec_nxt = vec_field(vec_watchdog_r, VEC_LO_LSB);
      default: begin
        if (interrupt_control_reg_r[CTL_EXTVEC_BIT]) begin
          vec_nxt = ext_vector_in; // see RULE10
        end else begin
          vec_nxt = ext_auto_vec;
        end
      end
    endcase
  end

  // Request held off in standby; priorities stay intact
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_request_r <= 1'b0;
      irq_level_r <= '0;
      irq_vector_r <= '0;
      irq_vector_addr_r <= '0;
    end else if (manual_rst) begin
      irq_request_r <= 1'b0;
      irq_level_r <= '0;
      irq_vector_r <= '0;
      irq_vector_addr_r <= '0;
    end else begin
      irq_request_r <= win_found && !standby;
      irq_level_r <= win_found ? win_level : '0;
      irq_vector_r <= vec_nxt; // see RULE17
      irq_vector_addr_r <= vector_base_r + {23'h0, vec_nxt, 2'b00}; // see RULE16
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq_request = irq_request_r;
  assign irq_level = irq_level_r;
  assign irq_vector = irq_vector_r;
  assign irq_vector_addr = irq_vector_addr_r;
  assign ethernet_dma_event = eth_event;
endmodule // peripheral_interrupt_priority_vectoring
`default_nettype wire

// >>> vectoring_sva.sv
`default_nettype none
module vectoring_sva
  import vectoring_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic manual_rst,
  input wire logic standby,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic dma0_req,
  input wire logic dma1_req,
  input wire logic watchdog_interval_event,
  input wire logic refresh_compare_match,
  input wire logic [3:0] encoded_level_inputs,
  input wire logic [3:0] irq_pins,
  input wire logic [ETH_CAUSES-1:0] eth_cause_set,
  input wire logic [LINK_CAUSES-1:0] link_cause_set,
  input wire logic irq_request,
  input wire logic [VEC_W-1:0] irq_vector,
  input wire logic [31:0] irq_vector_addr,
  input wire logic ethernet_dma_event
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  AST_RST_RELEASE: assert property ($past(rst) |-> !irq_request && !pready && !ethernet_dma_event)
    else $error("outputs not quiet after reset");
  AST_MANUAL_CLEAR: assert property (manual_rst |=> !irq_request && !ethernet_dma_event && prdata == 32'h0)
    else $error("manual reset left outputs set");
  AST_STANDBY_HOLD: assert property (standby |=> !irq_request)
    else $error("request raised in standby");
  AST_PRIO_RSVD: assert property (psel && penable && pready && !pwrite && paddr == OFF_PRIO_A
    |-> prdata[31:12] == 20'h0 && prdata[3:0] == 4'h0)
    else $error("reserved priority bits read nonzero");
  AST_VEC_B_ERR: assert property (psel && penable && pready && paddr == OFF_VECTOR_NUMBER_B
    |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("reserved vector register not refused");
  // Level sources only: with every input idle nothing may win
  AST_QUIET: assert property (!dma0_req && !dma1_req && !watchdog_interval_event && !refresh_compare_match
    && irq_pins == 4'h0 && encoded_level_inputs == 4'h0 |=> !irq_request)
    else $error("request without a source");
  AST_ETH_CAUSE: assert property ($rose(ethernet_dma_event) |-> $past(eth_cause_set, 2) != '0
    || $past(link_cause_set, 2) != '0 || ($past(psel, 2) && $past(pwrite, 2)))
    else $error("ethernet event without a cause");
  // Register writes excluded: the base may move with the vector
  AST_VEC_ADDR: assert property (irq_request && $past(irq_request) && !$stable(irq_vector)
    && !$past(psel) && !$past(psel, 2) |-> irq_vector_addr - $past(irq_vector_addr)
    == ({25'h0, irq_vector} - {25'h0, $past(irq_vector)}) << 2)
    else $error("vector address step not four per number");
endmodule // vectoring_sva
bind peripheral_interrupt_priority_vectoring vectoring_sva chk (
  .mclk, .rst, .manual_rst, .standby, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .dma0_req, .dma1_req, .watchdog_interval_event, .refresh_compare_match, .encoded_level_inputs,
  .irq_pins, .eth_cause_set, .link_cause_set, .irq_request, .irq_vector, .irq_vector_addr, .ethernet_dma_event
);
`default_nettype wire

// >>> periph_sources.sv
`default_nettype none
module periph_sources (
  input wire logic mclk,
  input wire logic [3:0] want,
  input wire logic [6:0] ext_want,
  output logic [3:0] req = 4'h0,
  output logic [6:0] ext_vec = 7'h00
);
  timeunit 1ns;
  timeprecision 1ns;
  // Level requests held until the bench withdraws them
  always @(posedge mclk) begin
    req <= want;
    ext_vec <= ext_want;
  end
endmodule // periph_sources
`default_nettype wire

// >>> tb_top.sv
`default_nettype none
module tb_top
  import vectoring_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst = 1, manual_rst = 0, standby = 0, psel = 0, penable = 0, pwrite = 0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, irq_vector_addr;
  logic pready, pslverr, irq_request, ethernet_dma_event;
  logic [3:0] want = 4'h0, req, encoded_level_inputs = 4'h0, irq_pins = 4'h0, irq_level;
  logic [6:0] ext_want = 7'h00, ext_vec, irq_vector;
  logic [ETH_CAUSES-1:0] eth_cause_set = '0;
  logic [LINK_CAUSES-1:0] link_cause_set = '0;
  int err_count = 0, checks = 0;
  always #50 mclk = ~mclk;
  periph_sources src (.mclk, .want, .ext_want, .req, .ext_vec);
  peripheral_interrupt_priority_vectoring dut (
    .mclk, .rst, .manual_rst, .standby, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .dma0_req(req[0]), .dma1_req(req[1]), .watchdog_interval_event(req[2]), .refresh_compare_match(req[3]),
    .encoded_level_inputs, .irq_pins, .ext_vector_in(ext_vec), .eth_cause_set, .link_cause_set,
    .irq_request, .irq_level, .irq_vector, .irq_vector_addr, .ethernet_dma_event
  );
  task automatic report_and_stop;
    if (err_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Leading edge keeps psel from being driven twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    // No own limit: only the watchdog ends a hung transfer
    while (pready !== 1'b1) begin
      @(posedge mclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp, input logic ex_err);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    cmp(what, exp, r);
    cmp({what, "_err"}, {31'h0, ex_err}, {31'h0, e});
  endtask
  task automatic irq_chk(input logic [6:0] v, input logic [31:0] base);
    repeat (3) @(posedge mclk);
    cmp("irq_request", 32'h1, irq_request);
    cmp("irq_vector", {25'h0, v}, irq_vector);
    cmp("irq_vector_addr", base + {23'h0, v, 2'b00}, irq_vector_addr);
  endtask
  task automatic t_regs;
    rd_chk("prio_rst", OFF_PRIO_A, 32'h0, 1'b0);
    wr(OFF_PRIO_A, 32'hffff_ffff);
    rd_chk("prio_mask", OFF_PRIO_A, 32'h0000_0ff0, 1'b0);
    wr(OFF_PRIO_A, 32'h0000_0a50);
    rd_chk("prio_fields", OFF_PRIO_A, 32'h0000_0a50, 1'b0);
    wr(OFF_VEC_WATCHDOG, 32'hffff_ffff);
    rd_chk("vec_range", OFF_VEC_WATCHDOG, 32'h0000_7f7f, 1'b0);
    wr(OFF_VECTOR_NUMBER_B, 32'h0000_1234);
    rd_chk("vec_b", OFF_VECTOR_NUMBER_B, 32'h0, 1'b1);
    rd_chk("unmapped", 8'h30, 32'h0, 1'b1);
  endtask
  task automatic t_arb;
    wr(OFF_VECTOR_BASE, 32'h0000_1000);
    wr(OFF_VEC_DMA, 32'h0000_2211);
    wr(OFF_VEC_WATCHDOG, 32'h0000_3344);
    wr(OFF_PRIO_A, 32'h0000_0550);
    want <= 4'b0011;
    irq_chk(7'h11, 32'h1000);
    want <= 4'b1110;
    irq_chk(7'h22, 32'h1000);
    want <= 4'b1100;
    irq_chk(7'h33, 32'h1000);
    wr(OFF_PRIO_A, 32'h0000_0590);
    want <= 4'b1010;
    irq_chk(7'h44, 32'h1000);
    cmp("ref_level", 32'h9, irq_level);
    wr(OFF_PRIO_A, 32'h0000_0000);
    repeat (3) @(posedge mclk);
    cmp("masked", 32'h0, irq_request);
  endtask
  task automatic t_standby;
    wr(OFF_PRIO_A, 32'h0000_0a50);
    want <= 4'b0001;
    standby <= 1'b1;
    repeat (3) @(posedge mclk);
    cmp("standby_irq", 32'h0, irq_request);
    rd_chk("standby_prio", OFF_PRIO_A, 32'h0000_0a50, 1'b0);
    standby <= 1'b0;
    irq_chk(7'h11, 32'h1000);
    manual_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    manual_rst <= 1'b0;
    want <= 4'b0000;
    rd_chk("manual_prio", OFF_PRIO_A, 32'h0, 1'b0);
    rd_chk("manual_base", OFF_VECTOR_BASE, 32'h0, 1'b0);
  endtask
  task automatic t_ext;
    wr(OFF_CONTROL, 32'h2);
    ext_want <= 7'h5a;
    encoded_level_inputs <= 4'h7;
    irq_chk(7'h5a, 32'h0);
    cmp("enc_level", 32'h7, irq_level);
    wr(OFF_CONTROL, 32'h0);
    irq_chk(7'h47, 32'h0);
    wr(OFF_EXT_LEVELS, 32'h0000_0030);
    wr(OFF_CONTROL, 32'h1);
    irq_pins <= 4'b0100;
    irq_chk(7'h42, 32'h0);
    irq_pins <= 4'h0;
    encoded_level_inputs <= 4'h0;
  endtask
  // One-cycle set pulse, then two edges for status and event
  task automatic pulse(input logic [ETH_CAUSES-1:0] c, input logic [LINK_CAUSES-1:0] l);
    eth_cause_set <= c;
    link_cause_set <= l;
    @(posedge mclk);
    eth_cause_set <= '0;
    link_cause_set <= '0;
    repeat (2) @(posedge mclk);
  endtask
  task automatic t_eth;
    wr(OFF_ETH_ENABLE, 32'h0008_0004);
    pulse(19'h4, 3'h0);
    cmp("eth_event", 32'h1, ethernet_dma_event);
    wr(OFF_ETH_STATUS, 32'h4);
    pulse(19'h8, 3'h0);
    cmp("eth_disabled", 32'h0, ethernet_dma_event);
    wr(OFF_LINK_ENABLE, 32'h2);
    pulse(19'h0, 3'h2);
    cmp("link_event", 32'h1, ethernet_dma_event);
    rd_chk("eth_status", OFF_ETH_STATUS, 32'h0008_0008, 1'b0);
    wr(OFF_LINK_STATUS, 32'h2);
    wr(OFF_ETH_STATUS, 32'h8);
    repeat (2) @(posedge mclk);
    cmp("eth_cleared", 32'h0, ethernet_dma_event);
    rd_chk("eth_status_clr", OFF_ETH_STATUS, 32'h0, 1'b0);
    rd_chk("link_status_clr", OFF_LINK_STATUS, 32'h0, 1'b0);
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_arb();
    t_standby();
    t_ext();
    t_eth();
    report_and_stop();
  end
  // Whole run is under two hundred cycles; this span is ample
  initial begin
    #200000;
    err_count++;
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
